// file: verilog/nvb_ctrl.sv
// Data EEPROM byte access controller: registers, programming engine, array
// Operation
// - Address register low six bits select bytes 0..63; top bits read zero
// - Data register holds byte to program and receives byte read
// - Control bits 7:6 read zero; mode, irq enable, arm, start, read
// - Mode 00 erase+write 3.4 ms, 01 erase 1.8 ms, 10 write 1.8 ms
// - Writes to mode field ignored while start bit is set
// - System reset clears mode field unless programming is in progress
// - Ready interrupt held while enabled, global enable set and idle
// - Arm bit clears itself four cycles after being written
// - Start within four cycles of arming begins programming unless mode is 11; else no effect
// - Start bit stays set until programming time elapses
// - Setting start stalls the CPU for two cycles
// - Read strobe loads addressed byte into data register at once
// - Each read stalls the CPU for four cycles
// - While programming, no reads and no address changes
// - Programming started before a system reset runs to completion; power-on reset aborts it
// - While busy every other EEPROM operation is refused
// - Programming time is counted on the calibrated oscillator
`timescale 1ns/1ps
`default_nettype none

module nvb_ctrl #(
	parameter int unsigned OSC_HZ       = nvb_pkg::OSC_HZ_DEFAULT,
	parameter int unsigned ATOMIC_TICKS = int'((nvb_pkg::PROG_ATOMIC_US * longint'(OSC_HZ)
	                                      + nvb_pkg::US_PER_S - 1) / nvb_pkg::US_PER_S),
	parameter int unsigned SPLIT_TICKS  = int'((nvb_pkg::PROG_SPLIT_US * longint'(OSC_HZ)
	                                      + nvb_pkg::US_PER_S - 1) / nvb_pkg::US_PER_S)
) (
	input  wire logic               i_clk,
	input  wire logic               i_rst_n,
	input  wire logic               i_por_n,
	input  wire logic               i_osc_tick,
	input  wire logic               i_global_irq_en,
	input  wire nvb_pkg::nvb_io_type i_io,
	output logic [7:0]              o_rdata,
	output logic                    o_stall,
	output logic                    o_ready_irq
);
	import nvb_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	localparam int unsigned CW = $clog2(ATOMIC_TICKS + 1);

	logic [7:0]    mem_q [NVB_DEPTH];
	nvb_state_type state_q;
	logic [CW-1:0] tick_cnt_q;
	logic [1:0]    mode_q;
	logic [5:0]    addr_q;
	logic [7:0]    data_q;
	logic          irq_en_q;
	logic          arm_q;
	logic [2:0]    arm_cnt_q;
	logic [2:0]    stall_q;
	logic [5:0]    prog_addr_q;
	logic [7:0]    prog_data_q;
	logic [1:0]    prog_mode_q;
	logic          wr_ctrl;
	logic          busy;
	logic          start_req;
	logic          read_req;
	logic          prog_done;
	logic [7:0]    ctrl_view;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	// Start is refused outside the arm window, while busy, or in reserved mode
	assign busy      = (state_q == ST_PROG);
	assign wr_ctrl   = i_io.wr && (i_io.sel == SEL_CTRL);
	assign start_req = wr_ctrl && i_io.wdata[CTL_START] && arm_q && !busy
	                   && (mode_q != MODE_RSVD);
	assign read_req  = wr_ctrl && i_io.wdata[CTL_READ] && !busy;
	assign prog_done = busy && i_osc_tick && (tick_cnt_q == CW'(1));
	// Reserved bits and the self-clearing read strobe read as zero
	assign ctrl_view = {2'b00, mode_q, irq_en_q, arm_q, busy, 1'b0};

	// ----------------------------------------------------------------
	// Programming engine on the power-on reset only
	// ----------------------------------------------------------------
	// A system reset must not abort a cell operation, so only power-on clears it
	always_ff @(posedge i_clk or negedge i_por_n) begin
		if (!i_por_n) begin
			state_q    <= ST_IDLE;
			tick_cnt_q <= '0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (start_req) begin
						state_q <= ST_PROG;
						tick_cnt_q <= (mode_q == MODE_ATOMIC) ? CW'(ATOMIC_TICKS)
						              : CW'(SPLIT_TICKS);
					end
				end
				ST_PROG: begin
					// Time advances only on oscillator ticks, not on the CPU clock
					if (i_osc_tick) begin
						tick_cnt_q <= tick_cnt_q - CW'(1);
					end
					if (prog_done) begin
						state_q <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// Operands are latched at start so the running operation is self-contained
	always_ff @(posedge i_clk or negedge i_por_n) begin
		if (!i_por_n) begin
			prog_addr_q <= ADDR_RESET;
			prog_data_q <= DATA_RESET;
			prog_mode_q <= MODE_RESET;
		end else if (start_req) begin
			prog_addr_q <= addr_q;
			prog_data_q <= data_q;
			prog_mode_q <= mode_q;
		end
	end

	// Array update at the end of the programming time; write-only ANDs bits
	always_ff @(posedge i_clk) begin
		if (prog_done) begin
			unique case (prog_mode_q)
				MODE_ATOMIC: mem_q[prog_addr_q] <= prog_data_q;
				MODE_ERASE:  mem_q[prog_addr_q] <= ERASED_BYTE;
				MODE_WRITE:  mem_q[prog_addr_q] <= mem_q[prog_addr_q] & prog_data_q;
				MODE_RSVD:   mem_q[prog_addr_q] <= mem_q[prog_addr_q];
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Mode field
	// ----------------------------------------------------------------
	// System reset is sampled as a level so the clear can depend on busy
	always_ff @(posedge i_clk or negedge i_por_n) begin
		if (!i_por_n) begin
			mode_q <= MODE_RESET;
		end else if (!i_rst_n) begin
			if (!busy) begin
				mode_q <= MODE_RESET;
			end
		end else if (wr_ctrl && !busy) begin
			mode_q <= i_io.wdata[CTL_MODE_HI:CTL_MODE_LO];
		end
	end

	// ----------------------------------------------------------------
	// Address and data registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			addr_q <= ADDR_RESET;
		end else if (i_io.wr && (i_io.sel == SEL_ADDR) && !busy) begin
			addr_q <= i_io.wdata[NVB_AW-1:0];
		end
	end

	// A read fetch takes priority over a software write in the same cycle
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			data_q <= DATA_RESET;
		end else if (read_req) begin
			data_q <= mem_q[addr_q];
		end else if (i_io.wr && (i_io.sel == SEL_DATA)) begin
			data_q <= i_io.wdata;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt enable and arm window
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_en_q <= 1'b0;
		end else if (wr_ctrl) begin
			irq_en_q <= i_io.wdata[CTL_IRQ_EN];
		end
	end

	// Writing arm reloads the window; hardware drops it after four cycles
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			arm_q     <= 1'b0;
			arm_cnt_q <= '0;
		end else if (wr_ctrl && i_io.wdata[CTL_ARM]) begin
			arm_q     <= 1'b1;
			arm_cnt_q <= ARM_CYCLES;
		end else if (arm_q) begin
			arm_cnt_q <= arm_cnt_q - 3'h1;
			if (arm_cnt_q == 3'h1) begin
				arm_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// CPU stall and read port
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			stall_q <= '0;
		end else if (read_req) begin
			stall_q <= READ_STALL;
		end else if (start_req) begin
			stall_q <= PROG_STALL;
		end else if (stall_q != 3'h0) begin
			stall_q <= stall_q - 3'h1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= 8'h00;
		end else if (i_io.rd) begin
			unique case (i_io.sel)
				SEL_NONE: o_rdata <= 8'h00;
				SEL_ADDR: o_rdata <= {2'b00, addr_q};
				SEL_DATA: o_rdata <= data_q;
				SEL_CTRL: o_rdata <= ctrl_view;
			endcase
		end
	end

	assign o_stall     = (stall_q != 3'h0);
	// Level interrupt, held as long as the array can accept programming
	assign o_ready_irq = irq_en_q && i_global_irq_en && !busy;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// Arm window: high for four cycles after the write, low on the fifth
	AST_ARM_CLEARS: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(wr_ctrl && i_io.wdata[CTL_ARM]) ##1 (!wr_ctrl)[*4] |=> !arm_q)
		else $error("arm bit not cleared after four cycles");
	AST_ARM_HOLDS: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(wr_ctrl && i_io.wdata[CTL_ARM]) |=> arm_q[*4])
		else $error("arm bit dropped early");

	// Start acceptance and refusal
	AST_NO_START_UNARMED: assert property (
		@(posedge i_clk) disable iff (!i_por_n || !i_rst_n)
		(!busy && !arm_q) |=> !busy)
		else $error("programming started without arm");
	AST_START_BUSY: assert property (
		@(posedge i_clk) disable iff (!i_por_n || !i_rst_n)
		(wr_ctrl && i_io.wdata[CTL_START] && arm_q && !busy && mode_q != MODE_RSVD)
		|=> busy && ctrl_view[CTL_START])
		else $error("start not taken inside arm window");
	AST_RSVD_MODE_REFUSED: assert property (
		@(posedge i_clk) disable iff (!i_por_n || !i_rst_n)
		(wr_ctrl && i_io.wdata[CTL_START] && !busy && mode_q == MODE_RSVD) |=> !busy)
		else $error("programming started in reserved mode");
	AST_DONE_IDLE: assert property (
		@(posedge i_clk) disable iff (!i_por_n)
		prog_done |=> !busy)
		else $error("start bit not cleared at end of programming");
	AST_TICK_HOLD: assert property (
		@(posedge i_clk) disable iff (!i_por_n)
		(busy && !i_osc_tick) |=> $stable(tick_cnt_q))
		else $error("programming time advanced without an oscillator tick");

	// Locks while programming, and what a system reset may touch
	AST_MODE_LOCK: assert property (
		@(posedge i_clk) disable iff (!i_por_n)
		busy |=> (busy && $stable(mode_q)) || !busy)
		else $error("mode changed while programming");
	AST_ADDR_LOCK: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(busy && $past(busy)) |-> $stable(addr_q))
		else $error("address changed while programming");
	AST_READ_REFUSED: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(busy && wr_ctrl && i_io.wdata[CTL_READ]) |=> $stable(data_q))
		else $error("read performed while programming");
	AST_MODE_RESET: assert property (
		@(posedge i_clk) disable iff (!i_por_n)
		(!i_rst_n && !busy) |=> (mode_q == MODE_RESET))
		else $error("mode not cleared by reset while idle");
	AST_MODE_KEEP: assert property (
		@(posedge i_clk) disable iff (!i_por_n)
		(!i_rst_n && busy) |=> $stable(mode_q))
		else $error("mode cleared by reset while programming");
	AST_BUSY_KEEPS: assert property (
		@(posedge i_clk) disable iff (!i_por_n)
		(!i_rst_n && busy && !prog_done) |=> busy)
		else $error("reset aborted programming");

	// CPU stall lengths and the read path
	AST_PROG_STALL: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		(start_req && !read_req) |=> o_stall ##1 o_stall ##1 !o_stall)
		else $error("program stall is not two cycles");
	AST_READ_STALL: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		read_req |=> o_stall[*4] ##1 !o_stall)
		else $error("read stall is not four cycles");
	AST_READ_DATA: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		read_req |=> (data_q == $past(mem_q[addr_q])))
		else $error("read data not loaded");
	AST_IRQ: assert property (
		@(posedge i_clk) disable iff (!i_por_n || !i_rst_n)
		o_ready_irq == (irq_en_q && i_global_irq_en && state_q == ST_IDLE))
		else $error("ready interrupt level wrong");
	// Data register reads may use all eight bits; address and control may not
	AST_CTRL_RSVD: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		$past(i_io.rd && (i_io.sel != SEL_DATA)) |-> (o_rdata[7:6] == 2'b00))
		else $error("reserved bits read nonzero");

endmodule

`default_nettype wire

// file: verilog/nvb_pkg.sv
// Package for the byte-wide data EEPROM access controller
package nvb_pkg;

	// ----------------------------------------------------------------
	// Geometry and control register fields
	// ----------------------------------------------------------------
	localparam int unsigned NVB_DEPTH    = 64;
	localparam int unsigned NVB_AW       = 6;
	localparam int unsigned CTL_MODE_HI  = 5;
	localparam int unsigned CTL_MODE_LO  = 4;
	localparam int unsigned CTL_IRQ_EN   = 3;
	localparam int unsigned CTL_ARM      = 2;
	localparam int unsigned CTL_START    = 1;
	localparam int unsigned CTL_READ     = 0;

	// ----------------------------------------------------------------
	// Reset values and timing
	// ----------------------------------------------------------------
	localparam logic [1:0]  MODE_RESET      = 2'h0;
	localparam logic [7:0]  DATA_RESET      = 8'h00;
	localparam logic [5:0]  ADDR_RESET      = 6'h00;
	localparam logic [7:0]  ERASED_BYTE     = 8'hff;
	localparam logic [2:0]  ARM_CYCLES      = 3'h4;
	localparam logic [2:0]  PROG_STALL      = 3'h2;
	localparam logic [2:0]  READ_STALL      = 3'h4;
	localparam longint      PROG_ATOMIC_US  = 3400;
	localparam longint      PROG_SPLIT_US   = 1800;
	localparam longint      US_PER_S        = 1000000;
	localparam int unsigned OSC_HZ_DEFAULT  = 9600000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_ATOMIC = 2'b00,
		MODE_ERASE  = 2'b01,
		MODE_WRITE  = 2'b10,
		MODE_RSVD   = 2'b11
	} nvb_mode_type;

	typedef enum logic [1:0] {
		SEL_NONE = 2'b00,
		SEL_ADDR = 2'b01,
		SEL_DATA = 2'b10,
		SEL_CTRL = 2'b11
	} nvb_sel_type;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_PROG = 1'b1
	} nvb_state_type;

	// One I/O access from the CPU: select, strobes and write data
	typedef struct packed {
		nvb_sel_type sel;
		logic        wr;
		logic        rd;
		logic [7:0]  wdata;
	} nvb_io_type;

endpackage

// file: verif/nvb_osc_model.sv
// Calibrated timing oscillator stand-in: one tick every DIV clocks
`timescale 1ns/1ps
`default_nettype none
module nvb_osc_model #(
	parameter int DIV = 3
) (
	input  wire logic i_clk,
	output var logic  o_tick
);
	int cnt = 0;
	initial o_tick = 1'b0;
	// Pulse stays one cycle wide so the engine sees each period once
	always @(posedge i_clk) begin
		cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
		o_tick <= (cnt == DIV - 1);
	end
endmodule
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for the data EEPROM byte access controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import nvb_pkg::*;
	localparam int AT = 5;
	localparam int SP = 4;
	localparam int DV = 3;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       por_n = 1'b0;
	logic       gie = 1'b1;
	logic       tick;
	nvb_io_type io = '0;
	logic [7:0] rdata;
	logic       stall;
	logic       irq;
	int         mismatches = 0;
	int         checked = 0;
	int         lowc = 0;

	nvb_ctrl #(.ATOMIC_TICKS(AT), .SPLIT_TICKS(SP)) i_nvb_ctrl (
		.i_clk(clk), .i_rst_n(rst_n), .i_por_n(por_n), .i_osc_tick(tick),
		.i_global_irq_en(gie), .i_io(io), .o_rdata(rdata), .o_stall(stall),
		.o_ready_irq(irq));
	nvb_osc_model #(.DIV(DV)) i_nvb_osc_model (.i_clk(clk), .o_tick(tick));

	// Clock, and a count of cycles spent not ready (busy time)
	always #50 clk = ~clk;
	always @(posedge clk) lowc <= irq ? lowc : lowc + 1;

	// ----------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Returns just after the edge that takes the write
	task automatic wr(input nvb_sel_type s, input logic [7:0] d);
		@(posedge clk) io <= '{sel: s, wr: 1'b1, rd: 1'b0, wdata: d};
		@(posedge clk) io <= '0;
	endtask
	task automatic rd(input nvb_sel_type s, input logic [7:0] e, input string nm);
		@(posedge clk) io <= '{sel: s, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(posedge clk) io <= '0;
		#1 chk(nm, rdata, e);
	endtask
	// Ready interrupt doubles as the idle flag; bounded so a hang shows
	task automatic wait_idle();
		int n = 0;
		while (irq !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		chk("idle", {7'h0, irq}, 8'h01);
	endtask
	task automatic prog(input logic [1:0] m, input logic [5:0] a, input logic [7:0] d,
		input int t, input int x);
		int b;
		wait_idle();
		wr(SEL_CTRL, {2'b00, m, 4'h8});
		wr(SEL_ADDR, {2'b00, a});
		wr(SEL_DATA, d);
		wr(SEL_CTRL, {2'b00, m, 4'hc});
		wr(SEL_CTRL, {2'b00, m, 4'he});
		#1 b = lowc;
		chk("stall", {7'h0, stall}, 8'h01);
		repeat (2) @(posedge clk);
		#1 chk("stall end", {7'h0, stall}, 8'h00);
		if (x == 1) begin
			wr(SEL_CTRL, 8'h38);
			wr(SEL_ADDR, 8'h3f);
			wr(SEL_CTRL, 8'h09);
		end
		if (x == 2) begin
			@(posedge clk) rst_n <= 1'b0;
			@(posedge clk) rst_n <= 1'b1;
			wr(SEL_CTRL, 8'h08);
		end
		wait_idle();
		chk("busy time", 8'((lowc - b + DV - 1) / DV), 8'(t));
	endtask
	task automatic rdb(input logic [5:0] a, input logic [7:0] e);
		wr(SEL_ADDR, {2'b00, a});
		wr(SEL_CTRL, 8'h09);
		#1 chk("read stall", {7'h0, stall}, 8'h01);
		rd(SEL_DATA, e, "read data");
		repeat (2) @(posedge clk);
		#1 chk("read stall end", {7'h0, stall}, 8'h00);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		por_n <= 1'b1;
		rd(SEL_CTRL, 8'h00, "ctrl reset");
		wr(SEL_ADDR, 8'hff);
		rd(SEL_ADDR, 8'h3f, "addr field");
		wr(SEL_CTRL, 8'h04);
		for (int k = 0; k < 3; k++) begin
			rd(SEL_CTRL, (k < 2) ? 8'h04 : 8'h00, "arm");
		end
		wr(SEL_CTRL, 8'h02);
		rd(SEL_CTRL, 8'h00, "start unarmed");
		wr(SEL_CTRL, 8'h08);
		#1 chk("irq", {7'h0, irq}, 8'h01);
		@(posedge clk) gie <= 1'b0;
		#1 chk("irq masked", {7'h0, irq}, 8'h00);
		@(posedge clk) gie <= 1'b1;
		prog(2'b00, 6'h05, 8'ha5, AT, 1);
		rd(SEL_CTRL, 8'h08, "mode kept");
		rd(SEL_ADDR, 8'h05, "addr kept");
		rdb(6'h05, 8'ha5);
		prog(2'b01, 6'h05, 8'h00, SP, 0);
		rdb(6'h05, 8'hff);
		prog(2'b10, 6'h05, 8'h3c, SP, 0);
		rdb(6'h05, 8'h3c);
		wr(SEL_CTRL, 8'h38);
		wr(SEL_CTRL, 8'h3c);
		wr(SEL_CTRL, 8'h3e);
		#1 chk("mode 11 start", {7'h0, irq}, 8'h01);
		prog(2'b01, 6'h05, 8'h00, SP, 2);
		rd(SEL_CTRL, 8'h18, "mode over reset");
		rdb(6'h05, 8'hff);
		@(posedge clk) rst_n <= 1'b0;
		@(posedge clk) rst_n <= 1'b1;
		rd(SEL_CTRL, 8'h00, "mode reset idle");
		results();
	end
	initial begin
		repeat (3000) @(posedge clk);
		mismatches++;
		results();
	end
endmodule
`default_nettype wire
